/* File: logic/dd_cfg.svh */
`ifndef DD_CFG_SVH
`define DD_CFG_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define DD_IDX_DRAW_X 30'h07FFFD0
`define DD_IDX_DRAW_Y 30'h07FFFD2
`define DD_IDX_COLOUR 30'h07FFFD8
`define DD_IDX_RECT_GO 30'h07FFFDA
`define DD_IDX_LINE_GO 30'h07FFFDC
`define DD_IDX_VIEW_X 30'h07FFFDE
`define DD_IDX_VIEW_Y 30'h07FFFE0
`define DD_IDX_PAGE 30'h07FFFE2
`define DD_IDX_TOUCH_X 30'h07FFFF0
`define DD_IDX_DISP_CTRL 30'h07FFFFC

// ****************************************
// Field positions and widths
// ****************************************
`define DD_X_W 11
`define DD_Y_W 10
`define DD_GO_BIT 0
`define DD_WRITE_PAGE_LSB 0
`define DD_VIEW_PAGE_LSB 2
`define DD_MODE_BIT 7
`define DD_TOUCH_LSB 8
`define DD_PAL_MODE_LSB 6

// ****************************************
// Reset values
// ****************************************
`define DD_RST_COLOUR 16'h0000
`define DD_RST_X 11'h000
`define DD_RST_Y 10'h000
`define DD_RST_PAGE 2'h0
`define DD_RST_TOUCH 8'h00

// ****************************************
// Timing
// ****************************************
`define DD_CLK_MHZ 200
`define DD_DONE_PULSE_NS 1000

`endif

/* File: logic/dd_pkg.sv */
package dd_pkg;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		DD_PULSE_IDLE = 2'h0,
		DD_PULSE_LOW = 2'h1
	} dd_pulse_state_t;

	typedef enum logic {
		DD_COLOUR_PALETTE = 1'b0,
		DD_COLOUR_RGB565 = 1'b1
	} dd_colour_mode_t;

endpackage

/* File: logic/dd_done_if.sv */
`timescale 1ns/1ps

interface dd_done_if;
	logic fire;
	logic pulse_n;

	modport src (
		output fire,
		input pulse_n
	);

	modport gen (
		input fire,
		output pulse_n
	);
endinterface

/* File: logic/dd_done_pulse.sv */
`timescale 1ns/1ps
`include "dd_cfg.svh"

module dd_done_pulse (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Completion event in, low pulse out
	dd_done_if.gen done
);

	// ****************************************
	// Pulse width
	// ****************************************
	localparam int PULSE_CYC_RAW = (`DD_DONE_PULSE_NS * `DD_CLK_MHZ) / 1000;
	localparam int PULSE_CYC = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
	localparam logic [8:0] PULSE_LAST = 9'(PULSE_CYC - 1);

	dd_pkg::dd_pulse_state_t state;
	dd_pkg::dd_pulse_state_t next_state;
	logic [8:0] count;

	// ****************************************
	// State machine
	// ****************************************
	always_comb begin
		next_state = state;
		case (state)
			dd_pkg::DD_PULSE_IDLE: begin
				if (done.fire) begin
					next_state = dd_pkg::DD_PULSE_LOW;
				end
			end
			dd_pkg::DD_PULSE_LOW: begin
				if (!done.fire && count == PULSE_LAST) begin
					next_state = dd_pkg::DD_PULSE_IDLE;
				end
			end
			default: begin
				next_state = dd_pkg::DD_PULSE_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= dd_pkg::DD_PULSE_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Width counter, restarted by a new event
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= 9'h000;
		end else if (done.fire) begin
			count <= 9'h000;
		end else if (state == dd_pkg::DD_PULSE_LOW) begin
			count <= count + 9'h001;
		end
	end

	// Active-low output straight from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done.pulse_n <= 1'b1;
		end else begin
			done.pulse_n <= (next_state != dd_pkg::DD_PULSE_LOW);
		end
	end

endmodule

/* File: logic/dd_draw_regs.sv */
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "dd_cfg.svh"

// Contract
// - In RGB mode colour is 16 bits: red 15..11, green 10..5, blue 4..0.
// - The drawing colour feeds rectangle fill, line drawing and hardware fill.
// - Colour and display-start registers accept byte and whole-word writes.
// - Writing one to the rectangle trigger bit launches a rectangle fill.
// - Writing one to the line trigger bit launches a line draw.
// - Trigger bits reset to zero and self-clear once the operation has begun.
// - Finishing a fill or line gives one active-low pulse of about 1 us.
// - Display start X is eleven bits, 0 to 2047; upper bits unused.
// - Display start Y is ten bits, 0 to 1023.
// - New display start coordinates apply only at the next frame start.
// - Page register bits 3..2 pick the displayed area 1 to 4.
// - All pixel writers target the selected write area.
// - Touch X register is read-only, sample in bits 15..8, resets to zero.
// - Fill and line start coordinates come from the drawing-start registers.
// - Colour-mode bit selects palette (0) or RGB565 (1) interpretation.
// - Touch low byte reads zero; new samples load automatically.
module dd_draw_regs (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Display timing
	input wire logic frame_start,
	// Drawing engine handshake
	input wire logic rect_begun,
	input wire logic line_begun,
	input wire logic rect_done,
	input wire logic line_done,
	output logic rect_go,
	output logic line_go,
	output logic done_pulse_n,
	// Drawing parameters
	output logic [10:0] draw_start_x,
	output logic [9:0] draw_start_y,
	output logic colour_is_rgb,
	output logic [15:0] pixel_colour,
	output logic [5:0] palette_index,
	output logic [1:0] palette_mode,
	// Display window and pages
	output logic [10:0] view_x,
	output logic [9:0] view_y,
	output logic [1:0] view_page,
	output logic [1:0] write_page,
	// Touch sample from the same-clock receiver
	input wire logic touch_valid,
	input wire logic [7:0] touch_sample
);

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic [3:0] dd_lanes(input logic [2:0] size, input logic [1:0] a);
		logic [3:0] lanes;
		lanes = 4'hF;
		case (size)
			3'h0: lanes = 4'h1 << a;
			3'h1: lanes = a[1] ? 4'hC : 4'h3;
			default: lanes = 4'hF;
		endcase
		return lanes;
	endfunction

	function automatic logic [15:0] dd_merge16(input logic [15:0] old,
		input logic [15:0] wd, input logic [1:0] be);
		logic [15:0] res;
		res = old;
		if (be[0]) begin
			res[7:0] = wd[7:0];
		end
		if (be[1]) begin
			res[15:8] = wd[15:8];
		end
		return res;
	endfunction

	// ****************************************
	// Bus phases
	// ****************************************
	logic addr_ok;
	logic wr_pend;
	logic [29:0] wr_idx;
	logic [3:0] wr_be;
	logic [31:0] next_hrdata;
	logic [15:0] colour_reg;
	logic [10:0] view_x_pend;
	logic [9:0] view_y_pend;
	logic [15:0] wd16;
	logic wr_colour;
	logic wr_rect;
	logic wr_line;
	logic wr_view_x;
	logic wr_view_y;
	logic wr_draw_x;
	logic wr_draw_y;
	logic wr_page;
	logic wr_ctrl;
	logic [7:0] touch_x;
	logic [15:0] draw_x_wd;
	logic [15:0] draw_y_wd;
	logic [15:0] view_x_wd;
	logic [15:0] view_y_wd;

	assign addr_ok = hsel && htrans[1] && hready;
	assign wd16 = hwdata[15:0];
	assign wr_colour = wr_pend && wr_idx == `DD_IDX_COLOUR;
	assign wr_rect = wr_pend && wr_idx == `DD_IDX_RECT_GO && wr_be[0];
	assign wr_line = wr_pend && wr_idx == `DD_IDX_LINE_GO && wr_be[0];
	assign wr_view_x = wr_pend && wr_idx == `DD_IDX_VIEW_X;
	assign wr_view_y = wr_pend && wr_idx == `DD_IDX_VIEW_Y;
	assign wr_draw_x = wr_pend && wr_idx == `DD_IDX_DRAW_X;
	assign wr_draw_y = wr_pend && wr_idx == `DD_IDX_DRAW_Y;
	assign wr_page = wr_pend && wr_idx == `DD_IDX_PAGE && wr_be[0];
	assign wr_ctrl = wr_pend && wr_idx == `DD_IDX_DISP_CTRL && wr_be[0];

	// Byte-lane merged write values for the coordinate registers
	assign draw_x_wd = dd_merge16({5'h00, draw_start_x}, wd16, wr_be[1:0]);
	assign draw_y_wd = dd_merge16({6'h00, draw_start_y}, wd16, wr_be[1:0]);
	assign view_x_wd = dd_merge16({5'h00, view_x_pend}, wd16, wr_be[1:0]);
	assign view_y_wd = dd_merge16({6'h00, view_y_pend}, wd16, wr_be[1:0]);

	// Write address phase captured, data applied next cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_idx <= 30'h0000000;
			wr_be <= 4'h0;
		end else begin
			wr_pend <= addr_ok && hwrite;
			if (addr_ok && hwrite) begin
				wr_idx <= haddr[31:2];
				wr_be <= dd_lanes(hsize, haddr[1:0]);
			end
		end
	end

	// Zero-wait slave, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	always_comb begin
		next_hrdata = 32'h00000000;
		case (haddr[31:2])
			`DD_IDX_DRAW_X: next_hrdata[10:0] = draw_start_x;
			`DD_IDX_DRAW_Y: next_hrdata[9:0] = draw_start_y;
			`DD_IDX_COLOUR: next_hrdata[15:0] = colour_reg;
			`DD_IDX_RECT_GO: next_hrdata[`DD_GO_BIT] = rect_go;
			`DD_IDX_LINE_GO: next_hrdata[`DD_GO_BIT] = line_go;
			`DD_IDX_VIEW_X: next_hrdata[10:0] = view_x_pend;
			`DD_IDX_VIEW_Y: next_hrdata[9:0] = view_y_pend;
			`DD_IDX_PAGE: next_hrdata[3:0] = {view_page, write_page};
			`DD_IDX_TOUCH_X: next_hrdata[15:0] = {touch_x, 8'h00};
			`DD_IDX_DISP_CTRL: next_hrdata[`DD_MODE_BIT] = colour_is_rgb;
			default: next_hrdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (addr_ok && !hwrite) begin
			hrdata <= next_hrdata;
		end
	end

	// ****************************************
	// Drawing colour and mode
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			colour_reg <= `DD_RST_COLOUR;
		end else if (wr_colour) begin
			colour_reg <= dd_merge16(colour_reg, wd16, wr_be[1:0]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			colour_is_rgb <= dd_pkg::DD_COLOUR_PALETTE;
		end else if (wr_ctrl) begin
			colour_is_rgb <= hwdata[`DD_MODE_BIT];
		end
	end

	// Colour presented to every pixel writer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pixel_colour <= `DD_RST_COLOUR;
			palette_index <= 6'h00;
			palette_mode <= 2'h0;
		end else begin
			if (colour_is_rgb == dd_pkg::DD_COLOUR_RGB565) begin
				pixel_colour <= colour_reg;
			end else begin
				pixel_colour <= {8'h00, colour_reg[7:0]};
			end
			palette_index <= colour_reg[5:0];
			palette_mode <= colour_reg[`DD_PAL_MODE_LSB +: 2];
		end
	end

	// ****************************************
	// Drawing start coordinates
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			draw_start_x <= `DD_RST_X;
			draw_start_y <= `DD_RST_Y;
		end else begin
			if (wr_draw_x) begin
				draw_start_x <= draw_x_wd[10:0];
			end
			if (wr_draw_y) begin
				draw_start_y <= draw_y_wd[9:0];
			end
		end
	end

	// ****************************************
	// Triggers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rect_go <= 1'b0;
		end else if (wr_rect && hwdata[`DD_GO_BIT]) begin
			rect_go <= 1'b1;
		end else if (rect_begun) begin
			rect_go <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			line_go <= 1'b0;
		end else if (wr_line && hwdata[`DD_GO_BIT]) begin
			line_go <= 1'b1;
		end else if (line_begun) begin
			line_go <= 1'b0;
		end
	end

	// ****************************************
	// Completion pulse
	// ****************************************
	dd_done_if done_bus ();

	assign done_bus.fire = rect_done || line_done;
	assign done_pulse_n = done_bus.pulse_n;

	dd_done_pulse u_done_pulse (
		.hclk(hclk),
		.hresetn(hresetn),
		.done(done_bus)
	);

	// ****************************************
	// Display start, staged to frame start
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			view_x_pend <= `DD_RST_X;
			view_y_pend <= `DD_RST_Y;
		end else begin
			if (wr_view_x) begin
				view_x_pend <= view_x_wd[10:0];
			end
			if (wr_view_y) begin
				view_y_pend <= view_y_wd[9:0];
			end
		end
	end

	// No range check on the coordinates
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			view_x <= `DD_RST_X;
			view_y <= `DD_RST_Y;
		end else if (frame_start) begin
			view_x <= view_x_pend;
			view_y <= view_y_pend;
		end
	end

	// ****************************************
	// Page selection
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			view_page <= `DD_RST_PAGE;
			write_page <= `DD_RST_PAGE;
		end else if (wr_page) begin
			view_page <= hwdata[`DD_VIEW_PAGE_LSB +: 2];
			write_page <= hwdata[`DD_WRITE_PAGE_LSB +: 2];
		end
	end

	// ****************************************
	// Touch sample
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			touch_x <= `DD_RST_TOUCH;
		end else if (touch_valid) begin
			touch_x <= touch_sample;
		end
	end

endmodule

/* File: dv/dd_draw_regs_props.sv */
`timescale 1ns/1ps
`include "dd_cfg.svh"

module dd_draw_regs_props (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// Engine and display
	input wire logic frame_start,
	input wire logic rect_begun,
	input wire logic rect_done,
	input wire logic line_done,
	input wire logic rect_go,
	input wire logic line_go,
	input wire logic done_pulse_n,
	input wire logic [10:0] view_x,
	input wire logic [9:0] view_y,
	input wire logic [1:0] view_page,
	input wire logic [1:0] write_page,
	input wire logic [5:0] palette_index,
	input wire logic [1:0] palette_mode
);
	logic wr_q;
	logic [29:0] addr_q;
	logic [15:0] wd_q;
	logic [10:0] pend_x;
	logic [7:0] since;
	logic [2:0] sz_q;
	logic [7:0] col_q;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ****************************************
	// Data phase tracking and pulse age
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			addr_q <= 30'h0;
			sz_q <= 3'h0;
			col_q <= 8'h00;
			wd_q <= 16'h0000;
			pend_x <= 11'h000;
			since <= 8'hFF;
		end else begin
			wr_q <= hsel && htrans[1] && hwrite && hready;
			addr_q <= (hsel && htrans[1] && hready) ? haddr[31:2] : addr_q;
			sz_q <= (hsel && htrans[1] && hready) ? hsize : sz_q;
			col_q <= (wr_q && addr_q == `DD_IDX_COLOUR && sz_q == 3'h2) ? hwdata[7:0] : col_q;
			wd_q <= hwdata[15:0];
			pend_x <= (wr_q && addr_q == `DD_IDX_VIEW_X) ? hwdata[10:0] : pend_x;
			since <= (rect_done || line_done) ? 8'h00 : (since == 8'hFF ? since : since + 8'h01);
		end
	end

	sequence s_wr(logic [29:0] idx);
		wr_q && addr_q == idx;
	endsequence
	sequence s_set(logic [29:0] idx);
		wr_q && addr_q == idx && hwdata[0];
	endsequence

	property p_okay; hreadyout && !hresp; endproperty
	property p_rect_set; s_set(`DD_IDX_RECT_GO) |=> rect_go; endproperty
	property p_line_set; s_set(`DD_IDX_LINE_GO) |=> line_go; endproperty
	property p_rect_clr;
		rect_go && rect_begun && !(wr_q && addr_q == `DD_IDX_RECT_GO && hwdata[0]) |=> !rect_go;
	endproperty
	property p_done_width; done_pulse_n == (since >= 8'hC8); endproperty
	property p_view_hold; !frame_start |=> $stable(view_x) && $stable(view_y); endproperty
	property p_view_take; frame_start && !wr_q |=> view_x == pend_x; endproperty
	property p_page; s_wr(`DD_IDX_PAGE) |=> {view_page, write_page} == wd_q[3:0]; endproperty
	property p_colour;
		wr_q && addr_q == `DD_IDX_COLOUR && sz_q == 3'h2 |=> ##1 palette_index == col_q[5:0] &&
			palette_mode == col_q[7:6];
	endproperty

	a_okay: assert property (p_okay)
		else $error("bus answer not ready or not okay");
	a_rect_set: assert property (p_rect_set)
		else $error("rectangle trigger not set");
	a_line_set: assert property (p_line_set)
		else $error("line trigger not set");
	a_rect_clr: assert property (p_rect_clr)
		else $error("rectangle trigger not cleared");
	a_done_width: assert property (p_done_width)
		else $error("done pulse width wrong");
	a_view_hold: assert property (p_view_hold)
		else $error("view origin moved mid frame");
	a_view_take: assert property (p_view_take)
		else $error("view origin not taken at frame");
	a_page: assert property (p_page)
		else $error("page select wrong");
	a_colour: assert property (p_colour)
		else $error("palette fields wrong");
endmodule

/* File: dv/dd_engine_model.sv */
`timescale 1ns/1ps

module dd_engine_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Pace select
	input wire logic slow,
	// Triggers in, events out
	input wire logic rect_go,
	input wire logic line_go,
	output logic rect_begun,
	output logic line_begun,
	output logic rect_done,
	output logic line_done
);
	logic busy;
	logic is_line;
	logic [5:0] cnt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy <= 1'b0;
			is_line <= 1'b0;
			cnt <= 6'h00;
			{rect_begun, line_begun, rect_done, line_done} <= 4'h0;
		end else begin
			{rect_begun, line_begun, rect_done, line_done} <= 4'h0;
			if (!busy && (rect_go || line_go)) begin
				busy <= 1'b1;
				is_line <= !rect_go;
				rect_begun <= rect_go;
				line_begun <= !rect_go;
				cnt <= slow ? 6'h28 : 6'h03;
			end else if (busy && cnt != 6'h00) begin
				cnt <= cnt - 6'h01;
			end else if (busy) begin
				busy <= 1'b0;
				rect_done <= !is_line;
				line_done <= is_line;
			end
		end
	end
endmodule

/* File: dv/dd_draw_regs_tb.sv */
`timescale 1ns/1ps
`include "dd_cfg.svh"

module dd_draw_regs_tb;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic frame_start = 1'b0, touch_valid = 1'b0, slow = 1'b0;
	logic [7:0] touch_sample = 8'h00;
	logic hreadyout, hresp, rect_begun, line_begun, rect_done, line_done;
	logic rect_go, line_go, done_pulse_n, colour_is_rgb;
	logic [10:0] draw_start_x, view_x;
	logic [9:0] draw_start_y, view_y;
	logic [15:0] pixel_colour;
	logic [5:0] palette_index;
	logic [1:0] palette_mode, view_page, write_page;
	int err_count = 0;
	int samples_checked = 0;

	always #2.5 hclk = ~hclk;

	dd_draw_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.frame_start(frame_start), .rect_begun(rect_begun), .line_begun(line_begun),
		.rect_done(rect_done), .line_done(line_done), .rect_go(rect_go), .line_go(line_go),
		.done_pulse_n(done_pulse_n), .draw_start_x(draw_start_x),
		.draw_start_y(draw_start_y), .colour_is_rgb(colour_is_rgb),
		.pixel_colour(pixel_colour), .palette_index(palette_index),
		.palette_mode(palette_mode), .view_x(view_x), .view_y(view_y),
		.view_page(view_page), .write_page(write_page), .touch_valid(touch_valid),
		.touch_sample(touch_sample));

	dd_engine_model u_eng (.hclk(hclk), .hresetn(hresetn), .slow(slow), .rect_go(rect_go),
		.line_go(line_go), .rect_begun(rect_begun), .line_begun(line_begun),
		.rect_done(rect_done), .line_done(line_done));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic guard(input int n, input int lim);
		if (n >= lim) begin
			err_count++;
			$display("[FAIL] wait ran out");
			results();
		end
	endtask

	task automatic bus(input logic [29:0] idx, input logic [1:0] off, input logic [2:0] sz,
		input logic w, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {idx, off};
		hsize <= sz;
		htrans <= 2'b10;
		hwrite <= w;
		n = 0;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		rd = hrdata;
		guard(n, 50);
	endtask

	task automatic wr(input logic [29:0] idx, input logic [31:0] d);
		logic [31:0] x;
		bus(idx, 2'h0, 3'h2, 1'b1, d, x);
	endtask

	task automatic wrp(input logic [29:0] idx, input logic [1:0] off, input logic [2:0] sz,
		input logic [31:0] d);
		logic [31:0] x;
		bus(idx, off, sz, 1'b1, d, x);
	endtask

	task automatic rdc(input string nm, input logic [29:0] idx, input logic [31:0] e);
		logic [31:0] x;
		bus(idx, 2'h0, 3'h2, 1'b0, 32'h0, x);
		chk(nm, x, e);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		rdc("colour rst", `DD_IDX_COLOUR, 32'h0);
		rdc("rect rst", `DD_IDX_RECT_GO, 32'h0);
		rdc("page rst", `DD_IDX_PAGE, 32'h0);
		rdc("touch rst", `DD_IDX_TOUCH_X, 32'h0);
		chk("done idle", 32'(done_pulse_n), 32'h1);
		$display("t_reset done");
	endtask

	task automatic t_colour;
		wr(`DD_IDX_COLOUR, 32'h0000F8C5);
		@(posedge hclk);
		#1 chk("index", 32'(palette_index), 32'h05);
		chk("mode bits", 32'(palette_mode), 32'h3);
		wr(`DD_IDX_DISP_CTRL, 32'h80);
		@(posedge hclk);
		#1 chk("rgb mode", 32'(colour_is_rgb), 32'h1);
		chk("rgb colour", 32'(pixel_colour), 32'hF8C5);
		wr(`DD_IDX_DISP_CTRL, 32'h0);
		@(posedge hclk);
		#1 chk("pal colour", 32'(pixel_colour), 32'h00C5);
		rdc("colour rd", `DD_IDX_COLOUR, 32'h0000F8C5);
		wrp(`DD_IDX_COLOUR, 2'h1, 3'h0, 32'h00003A00);
		rdc("colour byte", `DD_IDX_COLOUR, 32'h00003AC5);
		wrp(`DD_IDX_COLOUR, 2'h0, 3'h1, 32'h00001234);
		rdc("colour half", `DD_IDX_COLOUR, 32'h00001234);
		wrp(`DD_IDX_COLOUR, 2'h0, 3'h0, 32'h000000FF);
		rdc("colour low", `DD_IDX_COLOUR, 32'h000012FF);
		wr(`DD_IDX_DRAW_X, 32'h7FF);
		wr(`DD_IDX_DRAW_Y, 32'h3FF);
		#1 chk("start x", 32'(draw_start_x), 32'h7FF);
		chk("start y", 32'(draw_start_y), 32'h3FF);
		$display("t_colour done");
	endtask

	task automatic t_trig(input logic [29:0] idx, input logic ln, input logic pace);
		int n;
		@(posedge hclk);
		slow <= pace;
		wr(idx, 32'h0);
		#1 chk("go idle", 32'(ln ? line_go : rect_go), 32'h0);
		wr(idx, 32'h1);
		#1 chk("go set", 32'(ln ? line_go : rect_go), 32'h1);
		n = 0;
		while ((ln ? line_done : rect_done) !== 1'b1 && n < 100) begin
			@(posedge hclk);
			#1 n++;
		end
		guard(n, 100);
		chk("go cleared", 32'(ln ? line_go : rect_go), 32'h0);
		@(posedge hclk);
		#1 n = 0;
		while (done_pulse_n === 1'b0 && n < 300) begin
			@(posedge hclk);
			#1 n++;
		end
		chk("pulse cycles", 32'(n), 32'h000000C8);
		guard(n, 300);
		rdc("go read", idx, 32'h0);
		$display("t_trig done");
	endtask

	task automatic t_view;
		wr(`DD_IDX_VIEW_X, 32'h000007FF);
		wr(`DD_IDX_VIEW_Y, 32'h000003FF);
		#1 chk("x held", 32'(view_x), 32'h0);
		chk("y held", 32'(view_y), 32'h0);
		@(posedge hclk);
		frame_start <= 1'b1;
		@(posedge hclk);
		frame_start <= 1'b0;
		#1 chk("view x", 32'(view_x), 32'h7FF);
		chk("view y", 32'(view_y), 32'h3FF);
		$display("t_view done");
	endtask

	task automatic t_page;
		for (int i = 0; i < 16; i++) begin
			wr(`DD_IDX_PAGE, 32'(i));
			#1 chk("pages", 32'({view_page, write_page}), 32'(i));
		end
		$display("t_page done");
	endtask

	task automatic t_touch;
		@(posedge hclk);
		touch_valid <= 1'b1;
		touch_sample <= 8'hA5;
		@(posedge hclk);
		touch_valid <= 1'b0;
		rdc("touch", `DD_IDX_TOUCH_X, 32'h0000A500);
		wr(`DD_IDX_TOUCH_X, 32'h0000FFFF);
		rdc("touch ro", `DD_IDX_TOUCH_X, 32'h0000A500);
		wr(30'h07FFFE4, 32'hFFFFFFFF);
		rdc("unmapped", 30'h07FFFE4, 32'h0);
		$display("t_touch done");
	endtask

	task automatic t_rst2;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		#1 chk("view x rst", 32'(view_x), 32'h0);
		chk("done rst", 32'(done_pulse_n), 32'h1);
		rdc("page rst2", `DD_IDX_PAGE, 32'h0);
		rdc("touch rst2", `DD_IDX_TOUCH_X, 32'h0);
		rdc("colour rst2", `DD_IDX_COLOUR, 32'h0);
		$display("t_rst2 done");
	endtask

	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_colour();
		t_trig(`DD_IDX_RECT_GO, 1'b0, 1'b0);
		t_trig(`DD_IDX_LINE_GO, 1'b1, 1'b1);
		t_view();
		t_page();
		t_touch();
		t_rst2();
		results();
	end
endmodule

bind dd_draw_regs dd_draw_regs_props u_props (.*);
